/* File: verilog/uotg_pkg.sv */
package uotg_pkg;

    // Register byte offsets on the bus.
    localparam logic [7:0] UOTG_TOK_OFF   = 8'h00;
    localparam logic [7:0] UOTG_SOF_OFF   = 8'h04;
    localparam logic [7:0] UOTG_CFG1_OFF  = 8'h08;
    localparam logic [7:0] UOTG_CFG2_OFF  = 8'h0c;
    localparam logic [7:0] UOTG_PWR_OFF   = 8'h10;
    localparam logic [7:0] UOTG_STAT_OFF  = 8'h14;

    // Reset values of all writable registers.
    localparam logic [7:0] UOTG_TOK_RST   = 8'h00;
    localparam logic [7:0] UOTG_SOF_RST   = 8'h00;
    localparam logic [7:0] UOTG_CFG1_RST  = 8'h00;
    localparam logic [7:0] UOTG_CFG2_RST  = 8'h00;
    localparam logic [1:0] UOTG_PWR_RST   = 2'h0;

    // Writable bit masks; all other bits read as zero.
    localparam logic [7:0] UOTG_CFG1_MASK = 8'hd3;
    localparam logic [7:0] UOTG_CFG2_MASK = 8'h3f;

    // Token type codes.
    localparam logic [3:0] UOTG_PID_SETUP = 4'hd;
    localparam logic [3:0] UOTG_PID_IN    = 4'h9;
    localparam logic [3:0] UOTG_PID_OUT   = 4'h1;

    // Ping-pong layout codes.
    localparam logic [1:0] UOTG_PP_NONE  = 2'h0;
    localparam logic [1:0] UOTG_PP_OUT0  = 2'h1;
    localparam logic [1:0] UOTG_PP_ALL   = 2'h2;
    localparam logic [1:0] UOTG_PP_EP1UP = 2'h3;

    // Field positions.
    localparam int UOTG_EYE_BIT    = 7;
    localparam int UOTG_OEMON_BIT  = 6;
    localparam int UOTG_SIDL_BIT   = 4;
    localparam int UOTG_CMPSEL_BIT = 5;
    localparam int UOTG_PUV_BIT    = 4;
    localparam int UOTG_I2C_BIT    = 3;
    localparam int UOTG_BSTDIS_BIT = 2;
    localparam int UOTG_CMPDIS_BIT = 1;
    localparam int UOTG_TRDIS_BIT  = 0;
    localparam int UOTG_PWREN_BIT  = 0;
    localparam int UOTG_HOST_BIT   = 1;
    localparam int UOTG_THRESH_OVH = 10;

    // Token engine step time and its cycle count at 100 MHz.
    localparam int UOTG_CLK_MHZ    = 100;
    localparam int UOTG_BIT_NS     = 80;
    localparam int UOTG_BIT_CYC    = (UOTG_BIT_NS * UOTG_CLK_MHZ + 999) / 1000;
    localparam int UOTG_TOK_BITS   = 32;

endpackage : uotg_pkg

/* File: verilog/uotg_tok_if.sv */
`timescale 1ns/100ps
// Handshake between the register slice and the token engine.
interface uotg_tok_if;
    logic       start;    // One-cycle launch pulse.
    logic [3:0] token_type_field;      // Token type.
    logic [3:0] ep;       // Endpoint number.
    logic       busy;     // High while a token runs.
    logic       tx_oe_n;  // Low while data lines are driven.
    modport ctl (output start, output token_type_field, output ep,
                 input busy, input tx_oe_n);
    modport eng (input start, input token_type_field, input ep,
                 output busy, output tx_oe_n);
endinterface : uotg_tok_if

/* File: verilog/uotg_tok_eng.sv */
`timescale 1ns/100ps
// Token engine: runs one token for a fixed bit-time budget.
module uotg_tok_eng
    import uotg_pkg::*;
(
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Gating from configuration.
    input wire logic run_en,
    // Token handshake.
    uotg_tok_if.eng  tok
);

    typedef enum logic [1:0] {UOTG_IDLE, UOTG_TX, UOTG_RX} uotg_eng_e;

    uotg_eng_e   state_r;   // Engine state.
    logic [7:0]  bitcnt_r;  // Bit times left in the token.
    logic [7:0]  div_r;     // Bit-time divider.
    logic        bit_en;    // One-cycle enable per bit time.

    // Bit-time divider gives the engine its slower rate.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 8'h00;
        end else if (state_r == UOTG_IDLE ||
                     div_r == 8'(UOTG_BIT_CYC - 1)) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end
    assign bit_en = (div_r == 8'(UOTG_BIT_CYC - 1));

    // SETUP, OUT and any other code transmit; only IN receives.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r  <= UOTG_IDLE;
            bitcnt_r <= 8'h00;
        end else begin
            case (state_r)
                UOTG_IDLE: begin
                    if (tok.start && run_en) begin
                        bitcnt_r <= 8'(UOTG_TOK_BITS);
                        if (tok.token_type_field == UOTG_PID_IN) begin
                            state_r <= UOTG_RX;
                        end else begin
                            state_r <= UOTG_TX;
                        end
                    end
                end
                UOTG_TX, UOTG_RX: begin
                    // Halting mid-token drops it so the bus is freed.
                    if (!run_en) begin
                        state_r <= UOTG_IDLE;
                    end else if (bit_en) begin
                        if (bitcnt_r == 8'h01) begin
                            state_r <= UOTG_IDLE;
                        end
                        bitcnt_r <= bitcnt_r - 8'h01;
                    end
                end
                default: state_r <= UOTG_IDLE;
            endcase
        end
    end

    // Busy and drive indications.
    assign tok.busy    = (state_r != UOTG_IDLE);
    assign tok.tx_oe_n = (state_r != UOTG_TX);

endmodule : uotg_tok_eng

/* File: verilog/uotg_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Token codes: SETUP 1101, IN 1001, OUT 0001.
// - Threshold holds ten plus packet length.
// - Eye test bit drives eye test.
// - Monitor bit enables active-low drive signal.
// - Monitor acts only with transceiver disabled.
// - Stop-in-idle halts module in Idle.
// - Ping-pong field selects even/odd layout.
// - Comparator select picks three or two pins.
// - Pull-up bit enables bus power pull-up.
// - Control bit picks serial or dedicated pins.
// - Boost disable swaps to digital output.
// - Comparator disable swaps to digital input.
// - Transceiver disable swaps to digital interface.
// - Unimplemented bits read as zero.
// - Power enable bit enables the module.
module uotg_top
    import uotg_pkg::*;
(
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Device state.
    input  wire logic        cpu_idle,
    // Link-side controls.
    output logic             eye_test_en,
    output logic             oe_monitor_n,
    output logic             module_run,
    output logic [1:0]       pingpong_layout,
    output logic             pp_ep0_out,
    output logic             pp_ep0_in,
    output logic             pp_ep_other,
    output logic             ext_cmp_3pin,
    output logic             ext_cmp_2pin,
    output logic             bus_power_pullup,
    output logic             ext_ctl_serial,
    output logic             ext_ctl_pins,
    output logic             boost_on,
    output logic             boost_dig_out_en,
    output logic             cmp_on,
    output logic             cmp_dig_in_en,
    output logic             xcvr_on,
    output logic             xcvr_dig_en,
    output logic [7:0]       frame_threshold_value,
    output logic             token_busy_flag
);

    // Register storage; only implemented bits are held.
    logic [7:0] tok_r;        // Token type and endpoint.
    logic [7:0] sof_r;        // Frame threshold count.
    logic [7:0] cfg1_r;       // First configuration register.
    logic [7:0] cfg2_r;       // Second configuration register.
    logic [1:0] pwr_r;        // Power enable and host mode.

    // Bus pipeline state.
    logic       wr_pend_r;    // A write data phase is due.
    logic [7:0] wr_addr_r;    // Offset captured in the address phase.
    logic       tok_start_r;  // Launch pulse to the engine.
    logic       run_en;       // Module allowed to run.
    logic       addr_ok;      // Valid address phase.
    logic [31:0] rd_nxt;      // Read data for the address phase.

    uotg_tok_if tok_if ();

    // Token engine instance.
    uotg_tok_eng u_eng (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run_en  (run_en),
        .tok     (tok_if.eng)
    );

    assign tok_if.start = tok_start_r;
    assign tok_if.token_type_field   = tok_r[7:4];
    assign tok_if.ep    = tok_r[3:0];

    // Run only when powered and not halted by idle.
    assign run_en = pwr_r[UOTG_PWREN_BIT] &&
                    !(cfg1_r[UOTG_SIDL_BIT] && cpu_idle);

    // Transfer accepted on a selected, ready, non-idle cycle.
    assign addr_ok = hsel && hready && htrans[1];

    // Zero-wait slave; single word transfers only.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (hready) begin
            wr_pend_r <= addr_ok && hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    // Read mux; upper bits and unmapped addresses read zero.
    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (haddr[7:0])
            UOTG_TOK_OFF:  rd_nxt[7:0] = tok_r;
            UOTG_SOF_OFF:  rd_nxt[7:0] = sof_r;
            UOTG_CFG1_OFF: rd_nxt[7:0] = cfg1_r & UOTG_CFG1_MASK;
            UOTG_CFG2_OFF: rd_nxt[7:0] = cfg2_r & UOTG_CFG2_MASK;
            UOTG_PWR_OFF:  rd_nxt[1:0] = pwr_r;
            UOTG_STAT_OFF: rd_nxt[0]   = tok_if.busy;
            default:       rd_nxt      = 32'h0000_0000;
        endcase
    end

    // Read data registered so it is ready in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_nxt;
        end
    end

    // Slave is always ready and always answers OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Register writes in the data phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tok_r  <= UOTG_TOK_RST;
            sof_r  <= UOTG_SOF_RST;
            cfg1_r <= UOTG_CFG1_RST;
            cfg2_r <= UOTG_CFG2_RST;
            pwr_r  <= UOTG_PWR_RST;
        end else if (wr_pend_r) begin
            case (wr_addr_r)
                // Token stored as written; reserved codes are software's
                // burden and the engine treats them as transmit.
                UOTG_TOK_OFF:  tok_r  <= hwdata[7:0];
                UOTG_SOF_OFF:  sof_r  <= hwdata[7:0];
                UOTG_CFG1_OFF: cfg1_r <= hwdata[7:0] & UOTG_CFG1_MASK;
                // Disable bits are not locked while powered; software
                // must keep them still, as the hardware does not check.
                UOTG_CFG2_OFF: cfg2_r <= hwdata[7:0] & UOTG_CFG2_MASK;
                UOTG_PWR_OFF:  pwr_r  <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    // A token write in host mode launches one transaction.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tok_start_r <= 1'b0;
        end else begin
            tok_start_r <= wr_pend_r && (wr_addr_r == UOTG_TOK_OFF) &&
                           pwr_r[UOTG_HOST_BIT] && !tok_if.busy;
        end
    end

    // Busy flag mirrors the engine, including the launch cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            token_busy_flag <= 1'b0;
        end else begin
            token_busy_flag <= tok_if.busy || (tok_start_r && run_en);
        end
    end

    // Configuration outputs, registered.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eye_test_en           <= 1'b0;
            oe_monitor_n          <= 1'b1;
            module_run            <= 1'b0;
            frame_threshold_value <= 8'h00;
            bus_power_pullup      <= 1'b0;
            ext_ctl_serial        <= 1'b0;
            ext_ctl_pins          <= 1'b0;
        end else begin
            eye_test_en <= cfg1_r[UOTG_EYE_BIT] && run_en;
            // Drive indication only when monitor on and xcvr disabled.
            oe_monitor_n <= !(cfg1_r[UOTG_OEMON_BIT] &&
                              cfg2_r[UOTG_TRDIS_BIT] &&
                              !tok_if.tx_oe_n);
            module_run            <= run_en;
            frame_threshold_value <= sof_r;
            bus_power_pullup      <= cfg2_r[UOTG_PUV_BIT];
            ext_ctl_serial        <= cfg2_r[UOTG_I2C_BIT];
            ext_ctl_pins          <= !cfg2_r[UOTG_I2C_BIT];
        end
    end

    // Ping-pong layout decode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pingpong_layout <= UOTG_PP_NONE;
            pp_ep0_out      <= 1'b0;
            pp_ep0_in       <= 1'b0;
            pp_ep_other     <= 1'b0;
        end else begin
            pingpong_layout <= cfg1_r[1:0];
            case (cfg1_r[1:0])
                UOTG_PP_EP1UP: begin
                    pp_ep0_out  <= 1'b0;
                    pp_ep0_in   <= 1'b0;
                    pp_ep_other <= 1'b1;
                end
                UOTG_PP_ALL: begin
                    pp_ep0_out  <= 1'b1;
                    pp_ep0_in   <= 1'b1;
                    pp_ep_other <= 1'b1;
                end
                UOTG_PP_OUT0: begin
                    pp_ep0_out  <= 1'b1;
                    pp_ep0_in   <= 1'b0;
                    pp_ep_other <= 1'b0;
                end
                default: begin
                    pp_ep0_out  <= 1'b0;
                    pp_ep0_in   <= 1'b0;
                    pp_ep_other <= 1'b0;
                end
            endcase
        end
    end

    // On-chip analog blocks versus digital interfaces.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            boost_on         <= 1'b0;
            boost_dig_out_en <= 1'b0;
            cmp_on           <= 1'b0;
            cmp_dig_in_en    <= 1'b0;
            xcvr_on          <= 1'b0;
            xcvr_dig_en      <= 1'b0;
            ext_cmp_3pin     <= 1'b0;
            ext_cmp_2pin     <= 1'b0;
        end else begin
            boost_on         <= !cfg2_r[UOTG_BSTDIS_BIT];
            boost_dig_out_en <= cfg2_r[UOTG_BSTDIS_BIT];
            cmp_on           <= !cfg2_r[UOTG_CMPDIS_BIT];
            cmp_dig_in_en    <= cfg2_r[UOTG_CMPDIS_BIT];
            xcvr_on          <= !cfg2_r[UOTG_TRDIS_BIT];
            xcvr_dig_en      <= cfg2_r[UOTG_TRDIS_BIT];
            // Pin-count choice only matters with the comparator off.
            ext_cmp_3pin <= cfg2_r[UOTG_CMPDIS_BIT] &&
                            cfg2_r[UOTG_CMPSEL_BIT];
            ext_cmp_2pin <= cfg2_r[UOTG_CMPDIS_BIT] &&
                            !cfg2_r[UOTG_CMPSEL_BIT];
        end
    end

endmodule : uotg_top

/* File: sim/uotg_top_props.sv */
`timescale 1ns/100ps
// Relations between the block's ports that must hold every cycle.
module uotg_top_props
    import uotg_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Link-side controls.
    input wire logic        eye_test_en,
    input wire logic        oe_monitor_n,
    input wire logic        module_run,
    input wire logic [1:0]  pingpong_layout,
    input wire logic        pp_ep0_out,
    input wire logic        pp_ep0_in,
    input wire logic        pp_ep_other,
    input wire logic        ext_cmp_3pin,
    input wire logic        ext_cmp_2pin,
    input wire logic        ext_ctl_serial,
    input wire logic        ext_ctl_pins,
    input wire logic        boost_on,
    input wire logic        boost_dig_out_en,
    input wire logic        cmp_on,
    input wire logic        cmp_dig_in_en,
    input wire logic        xcvr_on,
    input wire logic        xcvr_dig_en,
    input wire logic        token_busy_flag
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A write address phase aimed at the token word.
    wire logic tok_ap = hsel && hready && htrans[1] && hwrite
                        && haddr[7:0] == UOTG_TOK_OFF;
    logic [15:0] busy_len_r; // Cycles the running token has been busy.
    // Counts busy cycles; cleared as soon as the engine goes quiet.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_len_r <= 16'h0000;
        end else if (token_busy_flag) begin
            busy_len_r <= busy_len_r + 16'h0001;
        end else begin
            busy_len_r <= 16'h0000;
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp && ~|hrdata[31:8])
        else $error("bus answer or upper read bits wrong");
    // The first edge after release still sees the reset levels.
    a_swap_sense: assert property ($past(hresetn) |->
        {boost_on, cmp_on, xcvr_on}
        == ~{boost_dig_out_en, cmp_dig_in_en, xcvr_dig_en})
        else $error("on-chip and digital selects not opposite");
    a_cmp_pins: assert property (!(ext_cmp_3pin && ext_cmp_2pin) &&
        ((ext_cmp_3pin || ext_cmp_2pin) == cmp_dig_in_en))
        else $error("comparator pin mode wrong");
    a_ctl_pins: assert property ($past(hresetn) |->
        ext_ctl_serial != ext_ctl_pins)
        else $error("external control path select wrong");
    a_pp_decode: assert property ({pp_ep0_out, pp_ep0_in, pp_ep_other}
        == (pingpong_layout == UOTG_PP_EP1UP ? 3'b001 :
            pingpong_layout == UOTG_PP_ALL   ? 3'b111 :
            pingpong_layout == UOTG_PP_OUT0  ? 3'b100 : 3'b000))
        else $error("ping-pong decode wrong");
    a_oe_gate: assert property (!oe_monitor_n |->
        (xcvr_dig_en || $past(xcvr_dig_en))
        && (token_busy_flag || $past(token_busy_flag)))
        else $error("drive marker low without cause");
    a_busy_cause: assert property ($rose(token_busy_flag) |->
        $past(tok_ap, 2) || $past(tok_ap, 3) || $past(tok_ap, 4))
        else $error("token started without a token write");
    a_busy_len: assert property ($fell(token_busy_flag) |->
        (busy_len_r >= 16'd250 && busy_len_r <= 16'd264)
        || !module_run || !$past(module_run))
        else $error("token busy length wrong");
    a_eye_run: assert property (eye_test_en |->
        module_run || $past(module_run))
        else $error("eye test on while module stopped");
endmodule : uotg_top_props

bind uotg_top uotg_top_props u_props (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .eye_test_en(eye_test_en),
    .oe_monitor_n(oe_monitor_n), .module_run(module_run),
    .pingpong_layout(pingpong_layout), .pp_ep0_out(pp_ep0_out),
    .pp_ep0_in(pp_ep0_in), .pp_ep_other(pp_ep_other),
    .ext_cmp_3pin(ext_cmp_3pin), .ext_cmp_2pin(ext_cmp_2pin),
    .ext_ctl_serial(ext_ctl_serial), .ext_ctl_pins(ext_ctl_pins),
    .boost_on(boost_on), .boost_dig_out_en(boost_dig_out_en),
    .cmp_on(cmp_on), .cmp_dig_in_en(cmp_dig_in_en), .xcvr_on(xcvr_on),
    .xcvr_dig_en(xcvr_dig_en), .token_busy_flag(token_busy_flag));

/* File: sim/uotg_dev_model.sv */
`timescale 1ns/100ps
// Attached device: counts tokens and the cycles the drive marker shows the host driving the lines.
module uotg_dev_model (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Host activity seen at the link.
    input  wire logic        token_busy_flag,
    input  wire logic        oe_monitor_n,
    // Counts handed to the bench.
    output logic      [7:0]  tok_cnt_r,
    output logic      [15:0] drv_cnt_r
);
    logic busy_r; // Busy level at the previous edge.
    // A rising busy is one token; a low drive marker is one driven cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_r    <= 1'b0;
            tok_cnt_r <= 8'h00;
            drv_cnt_r <= 16'h0000;
        end else begin
            busy_r <= token_busy_flag;
            if (token_busy_flag && !busy_r) begin
                tok_cnt_r <= tok_cnt_r + 8'h01;
            end
            if (!oe_monitor_n) begin
                drv_cnt_r <= drv_cnt_r + 16'h0001;
            end
        end
    end
endmodule : uotg_dev_model

/* File: sim/uotg_top_test.sv */
`timescale 1ns/100ps
// Self-checking bench for the register slice and its token engine.
module uotg_top_test
    import uotg_pkg::*;
;
    // Bus inputs, device state and wide outputs.
    logic        hclk, hresetn, hsel, hwrite, cpu_idle;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans, pingpong_layout;
    logic [2:0]  hsize;
    logic [7:0]  frame_threshold_value, tok_cnt_r;
    logic [15:0] drv_cnt_r;
    wire  logic  hready;
    // Single-bit outputs of the block.
    logic hreadyout, hresp, eye_test_en, oe_monitor_n, module_run;
    logic pp_ep0_out, pp_ep0_in, pp_ep_other, ext_cmp_3pin, ext_cmp_2pin;
    logic bus_power_pullup, ext_ctl_serial, ext_ctl_pins, boost_on;
    logic boost_dig_out_en, cmp_on, cmp_dig_in_en, xcvr_on, xcvr_dig_en;
    logic token_busy_flag;
    int   bad_count, n_checks, cycles;
    // The only slave's ready is the bus ready.
    assign hready = hreadyout;
    always #5 hclk = ~hclk;
    uotg_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cpu_idle(cpu_idle),
        .eye_test_en(eye_test_en), .oe_monitor_n(oe_monitor_n),
        .module_run(module_run), .pingpong_layout(pingpong_layout),
        .pp_ep0_out(pp_ep0_out), .pp_ep0_in(pp_ep0_in),
        .pp_ep_other(pp_ep_other), .ext_cmp_3pin(ext_cmp_3pin),
        .ext_cmp_2pin(ext_cmp_2pin), .bus_power_pullup(bus_power_pullup),
        .ext_ctl_serial(ext_ctl_serial), .ext_ctl_pins(ext_ctl_pins),
        .boost_on(boost_on), .boost_dig_out_en(boost_dig_out_en),
        .cmp_on(cmp_on), .cmp_dig_in_en(cmp_dig_in_en), .xcvr_on(xcvr_on),
        .xcvr_dig_en(xcvr_dig_en),
        .frame_threshold_value(frame_threshold_value),
        .token_busy_flag(token_busy_flag));
    uotg_dev_model u_dev (.hclk(hclk), .hresetn(hresetn),
        .token_busy_flag(token_busy_flag), .oe_monitor_n(oe_monitor_n),
        .tok_cnt_r(tok_cnt_r), .drv_cnt_r(drv_cnt_r));
    // Prints the verdict once and ends the run.
    task automatic final_report();
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    // Counts one comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One single transfer; holds each phase until ready is seen high.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge hclk);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask : bus
    // Lets a written value reach the registered outputs.
    task automatic settle();
        repeat (2) @(posedge hclk);
        #1;
    endtask : settle
    // Waits, bounded, for the token busy level.
    task automatic wait_busy(input logic lvl);
        for (int n = 0; n < 400 && token_busy_flag !== lvl; n++) begin
            @(posedge hclk);
        end
        chk("busy level", {31'h0, lvl}, {31'h0, token_busy_flag});
    endtask : wait_busy
    // Reset values, then masks, unmapped space and the threshold.
    task automatic t_regs();
        logic [7:0] msk [5] = '{8'hff, 8'hff, 8'hd3, 8'h3f, 8'h03};
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 8'(4 * i), 32'h0);
            chk("reset word", 32'h0, rdv);
            bus(1'b1, 8'(4 * i), 32'hffffffff);
            bus(1'b0, 8'(4 * i), 32'h0);
            chk("masked word", {24'h0, msk[i]}, rdv);
            bus(1'b1, 8'(4 * i), 32'h0);
        end
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rdv);
        bus(1'b1, UOTG_SOF_OFF, 32'(UOTG_THRESH_OVH + 64));
        settle();
        chk("threshold", 32'h4a, {24'h0, frame_threshold_value});
    endtask : t_regs
    // Every pattern of the second configuration word, power off.
    task automatic t_cfg2();
        logic [5:0] v;
        for (int i = 0; i < 64; i++) begin
            v = 6'(i);
            bus(1'b1, UOTG_CFG2_OFF, {26'h0, v});
            settle();
            chk("cfg2 outputs", {21'h0, v[1] & v[5], v[1] & ~v[5],
                v[4], v[3], ~v[3], ~v[2], v[2], ~v[1], v[1],
                ~v[0], v[0]},
                {21'h0, ext_cmp_3pin, ext_cmp_2pin, bus_power_pullup,
                ext_ctl_serial, ext_ctl_pins, boost_on, boost_dig_out_en,
                cmp_on, cmp_dig_in_en, xcvr_on, xcvr_dig_en});
        end
    endtask : t_cfg2
    // Power, idle and eye test against the run state.
    task automatic run_case(input logic [7:0] p, c, input logic idle,
                            input logic [1:0] e);
        bus(1'b1, UOTG_PWR_OFF, {24'h0, p});
        cpu_idle <= idle;
        bus(1'b1, UOTG_CFG1_OFF, {24'h0, c});
        settle();
        chk("run and eye", {30'h0, e}, {30'h0, module_run, eye_test_en});
    endtask : run_case
    // Run gating, then each ping-pong layout.
    task automatic t_run();
        logic [2:0] pp [4] = '{3'b000, 3'b100, 3'b111, 3'b001};
        run_case(8'h00, 8'h80, 1'b0, 2'b00);
        run_case(8'h01, 8'h80, 1'b0, 2'b11);
        run_case(8'h01, 8'h90, 1'b1, 2'b00);
        run_case(8'h01, 8'h80, 1'b1, 2'b11);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, UOTG_CFG1_OFF, 32'(i));
            settle();
            chk("ping-pong", {27'h0, 2'(i), pp[i]}, {27'h0,
                pingpong_layout, pp_ep0_out, pp_ep0_in, pp_ep_other});
        end
    endtask : t_run
    // Tokens of each type, then one with the monitor not in force.
    task automatic t_token();
        logic [3:0]  token_type_field [4] = '{UOTG_PID_SETUP, UOTG_PID_IN,
                                 UOTG_PID_OUT, UOTG_PID_OUT};
        logic [7:0]  t0;
        logic [15:0] d0;
        bus(1'b1, UOTG_PWR_OFF, 32'h0);
        bus(1'b1, UOTG_CFG2_OFF, 32'h1);
        bus(1'b1, UOTG_CFG1_OFF, 32'h40);
        bus(1'b1, UOTG_PWR_OFF, 32'h3);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                bus(1'b1, UOTG_PWR_OFF, 32'h0);
                bus(1'b1, UOTG_CFG2_OFF, 32'h0);
                bus(1'b1, UOTG_PWR_OFF, 32'h3);
            end
            t0 = tok_cnt_r;
            d0 = drv_cnt_r;
            bus(1'b1, UOTG_TOK_OFF, {24'h0, token_type_field[i], 4'(i)});
            wait_busy(1'b1);
            bus(1'b0, UOTG_STAT_OFF, 32'h0);
            chk("busy status", 32'h1, rdv);
            wait_busy(1'b0);
            chk("tokens", {24'h0, t0 + 8'h01}, {24'h0, tok_cnt_r});
            chk("driven", {31'h0, token_type_field[i] != UOTG_PID_IN && i < 3},
                {31'h0, drv_cnt_r != d0});
        end
    endtask : t_token
    // Cuts a hang short.
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    // Reset, then the scenarios in turn.
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'b010;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        cpu_idle = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        settle();
        chk("reset outputs", 32'h7c, {25'h0, xcvr_on, cmp_on, boost_on,
            ext_ctl_pins, oe_monitor_n, token_busy_flag, module_run});
        t_regs();
        t_cfg2();
        t_run();
        t_token();
        final_report();
    end
endmodule : uotg_top_test
